// [core/ddc_ctrl_regs.vh]
`ifndef DDC_CTRL_REGS_VH
`define DDC_CTRL_REGS_VH
`define IDX_PHASE_B 8'h0d
`define IDX_CHAN_CTRL 8'h0e
`define IDX_TEST_SEL 8'h0f
`define IDX_STEPS 8'h10
`define IDX_THRESH 8'h11
`define IDX_COUNTS 8'h12
`define IDX_GAIN_HI 8'h13
`define IDX_GAIN_A 8'h14
`define IDX_STATUS 8'h1f
`define RST_WORD 16'h0000
`define RST_GAIN_HI 16'h0000
`define RST_GAIN_A 16'h1000
`define RST_GAIN_WORD 24'h001000
`define MASK_CHAN_CTRL 16'hff07
`define MASK_TEST_SEL 16'h003f
`define MASK_COUNTS 16'h1f1f
`define BIT_DITHER_ON 15
`define BIT_METER_SYNC_OFF 12
`define BIT_CHAN_ON 11
`define BIT_MIX_SLOTS 10
`define BIT_MIX_BOOST 9
`define BIT_COEF_READ 8
`define BIT_Q_ZERO 2
`define BIT_SLOT_POS 1
`define BIT_STREAM_CNT 0
`define BIT_FREEZE 12
`define BIT_CLEAR 4
`define SHIFT_MIN 4'h3
`endif

// [core/ddc_channel_control_agc.v]
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "ddc_ctrl_regs.vh"
module ddc_channel_control_agc #(
  parameter CHANNEL = 0
) (
  // Clock and reset
  input wire CORE_CLK_IN,
  input wire RESET_IN,
  // APB slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output wire [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  // Datapath events and samples
  input wire SYNC_IN,
  input wire SAMPLE_VALID_IN,
  input wire signed [17:0] AGC_I_IN,
  input wire [17:0] FREQ_ACC_IN,
  input wire [35:0] TEST_SRC_0_IN,
  input wire [35:0] TEST_SRC_1_IN,
  input wire [35:0] TEST_SRC_2_IN,
  input wire [35:0] TEST_SRC_3_IN,
  input wire [35:0] TEST_SRC_4_IN,
  input wire [35:0] TEST_SRC_5_IN,
  input wire [35:0] TEST_SRC_6_IN,
  input wire [35:0] TEST_SRC_7_IN,
  input wire [35:0] TEST_SRC_8_IN,
  input wire [35:0] TEST_SRC_9_IN,
  input wire [35:0] TEST_SRC_10_IN,
  input wire [35:0] TEST_SRC_11_IN,
  // Controls to the datapath
  output reg [15:0] PHASE_B_OUT,
  output reg [15:0] NCO_B_PHASE_OUT,
  output reg [23:0] GAIN_WORD_OUT,
  output reg DITHER_ON_OUT,
  output reg [1:0] DITHER_MASK_OUT,
  output reg METER_SYNC_OUT,
  output reg CHAN_CLK_EN_OUT,
  output reg MIX_BOOST_OUT,
  output reg COEF_READ_OUT,
  output reg Q_ZERO_OUT,
  output reg STREAM_CNT_OUT,
  output reg SLOT_POS_OUT,
  output reg [4:0] ROUND_BITS_OUT,
  output reg signed [23:0] AGC_ACC_OUT,
  // Test bus pins
  output reg [15:0] RXIN_C_OUT,
  output reg [15:0] RXIN_D_OUT,
  output reg [5:0] DVGA_C_OUT,
  output reg [5:0] DVGA_D_OUT,
  output reg GAIN_FLAG_OUT
);

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  // Page (upper bits) must equal the low two bits of 2*CHANNEL+1
  localparam integer PAGE_NUM = 2 * CHANNEL + 1;
  localparam [1:0] PAGE_LO = PAGE_NUM[1:0];
  reg [15:0] phase_b_shadow_q;
  reg [15:0] chan_ctrl_q;
  reg [15:0] test_sel_q;
  reg [15:0] steps_q;
  reg [15:0] thresh_q;
  reg [15:0] counts_q;
  reg [15:0] gain_hi_shadow_q;
  reg [15:0] gain_lo_shadow_q;
  reg [3:0] zero_run_q;
  reg [3:0] sat_run_q;
  reg [31:0] prdata_q;
  wire [7:0] idx = PADDR_IN[9:2];
  wire page_hit = PADDR_IN[11:10] == PAGE_LO;
  wire wr = PSEL_IN && PENABLE_IN && PWRITE_IN && page_hit;
  wire rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN && page_hit;

  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = 1'b0;
  assign PRDATA_OUT = prdata_q;

  // ------------------------------------------------------------
  // Gain loop helpers
  // ------------------------------------------------------------
  // Shift field clamped to 3..15 range: larger shift, smaller step
  function [23:0] step_of;
    input [3:0] f;
    reg [4:0] sh;
    begin
      sh = (f < `SHIFT_MIN) ? {1'b0, `SHIFT_MIN} : {1'b0, f};
      step_of = 24'h800000 >> sh;
    end
  endfunction

  function [17:0] mag18;
    input signed [17:0] v;
    begin
      mag18 = v[17] ? (~v + 18'h00001) : v;
    end
  endfunction

  wire [17:0] mag = mag18(AGC_I_IN);
  wire [17:0] mag_masked = mag & ~{14'h0000, thresh_q[15:12]};
  wire is_zero = mag_masked == 18'h00000;
  wire is_full = mag[16:0] == 17'h1ffff;
  wire above = mag[17:10] > thresh_q[7:0];
  wire below = mag[17:10] < thresh_q[7:0];

  // ------------------------------------------------------------
  // Register writes, sync loads and reads
  // ------------------------------------------------------------
  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      phase_b_shadow_q <= `RST_WORD;
      chan_ctrl_q <= `RST_WORD;
      test_sel_q <= `RST_WORD;
      steps_q <= `RST_WORD;
      thresh_q <= `RST_WORD;
      counts_q <= `RST_WORD;
      gain_hi_shadow_q <= `RST_GAIN_HI;
      gain_lo_shadow_q <= `RST_GAIN_A;
      PHASE_B_OUT <= `RST_WORD;
      GAIN_WORD_OUT <= `RST_GAIN_WORD;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr) begin
        case (idx)
          `IDX_PHASE_B: phase_b_shadow_q <= PWDATA_IN[15:0];
          `IDX_CHAN_CTRL: chan_ctrl_q <= PWDATA_IN[15:0] & `MASK_CHAN_CTRL;
          `IDX_TEST_SEL: test_sel_q <= PWDATA_IN[15:0] & `MASK_TEST_SEL;
          `IDX_STEPS: steps_q <= PWDATA_IN[15:0];
          `IDX_THRESH: thresh_q <= PWDATA_IN[15:0];
          `IDX_COUNTS: counts_q <= PWDATA_IN[15:0] & `MASK_COUNTS;
          `IDX_GAIN_HI: gain_hi_shadow_q <= PWDATA_IN[15:0];
          `IDX_GAIN_A: gain_lo_shadow_q <= PWDATA_IN[15:0];
          default: ;
        endcase
      end
      if (SYNC_IN) begin
        PHASE_B_OUT <= phase_b_shadow_q;
        GAIN_WORD_OUT <= {gain_hi_shadow_q[15:8], gain_lo_shadow_q};
      end
      if (rd) begin
        case (idx)
          `IDX_PHASE_B: prdata_q <= {16'h0000, phase_b_shadow_q};
          `IDX_CHAN_CTRL: prdata_q <= {16'h0000, chan_ctrl_q};
          `IDX_TEST_SEL: prdata_q <= {16'h0000, test_sel_q};
          `IDX_STEPS: prdata_q <= {16'h0000, steps_q};
          `IDX_THRESH: prdata_q <= {16'h0000, thresh_q};
          `IDX_COUNTS: prdata_q <= {16'h0000, counts_q};
          `IDX_GAIN_HI: prdata_q <= {16'h0000, gain_hi_shadow_q};
          `IDX_GAIN_A: prdata_q <= {16'h0000, gain_lo_shadow_q};
          `IDX_STATUS: prdata_q <= {AGC_ACC_OUT, zero_run_q, sat_run_q};
          default: prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Channel controls
  // ------------------------------------------------------------
  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      NCO_B_PHASE_OUT <= 16'h0000;
      DITHER_ON_OUT <= 1'b0;
      DITHER_MASK_OUT <= 2'b00;
      METER_SYNC_OUT <= 1'b0;
      CHAN_CLK_EN_OUT <= 1'b0;
      MIX_BOOST_OUT <= 1'b0;
      COEF_READ_OUT <= 1'b0;
      Q_ZERO_OUT <= 1'b0;
      STREAM_CNT_OUT <= 1'b0;
      SLOT_POS_OUT <= 1'b0;
      ROUND_BITS_OUT <= 5'd18;
    end else begin
      NCO_B_PHASE_OUT <= FREQ_ACC_IN[17:2] + PHASE_B_OUT;
      DITHER_ON_OUT <= chan_ctrl_q[`BIT_DITHER_ON];
      DITHER_MASK_OUT <= chan_ctrl_q[14:13];
      METER_SYNC_OUT <= SYNC_IN && !chan_ctrl_q[`BIT_METER_SYNC_OFF];
      CHAN_CLK_EN_OUT <= chan_ctrl_q[`BIT_CHAN_ON];
      MIX_BOOST_OUT <= chan_ctrl_q[`BIT_MIX_BOOST];
      COEF_READ_OUT <= chan_ctrl_q[`BIT_COEF_READ];
      Q_ZERO_OUT <= chan_ctrl_q[`BIT_Q_ZERO];
      STREAM_CNT_OUT <= chan_ctrl_q[`BIT_STREAM_CNT];
      // Slot select limited to the stream count
      SLOT_POS_OUT <= chan_ctrl_q[`BIT_SLOT_POS] & chan_ctrl_q[`BIT_STREAM_CNT];
      ROUND_BITS_OUT <= 5'd18 - {1'b0, thresh_q[11:8]};
    end
  end

  // ------------------------------------------------------------
  // Test bus
  // ------------------------------------------------------------
  reg [35:0] tbus;
  reg tb_marks;
  always @* begin
    tb_marks = 1'b0;
    case (test_sel_q[5:0])
      6'h01: begin tbus = TEST_SRC_0_IN; tb_marks = 1'b1; end
      6'h02: begin tbus = TEST_SRC_1_IN; tb_marks = 1'b1; end
      6'h03: tbus = TEST_SRC_2_IN;
      6'h04: tbus = TEST_SRC_3_IN;
      6'h05: tbus = {16'h0000, TEST_SRC_4_IN[19:0]};
      6'h06: tbus = {16'h0000, TEST_SRC_5_IN[19:0]};
      6'h07: tbus = TEST_SRC_6_IN;
      6'h08: begin tbus = TEST_SRC_7_IN; tb_marks = 1'b1; end
      6'h09: tbus = TEST_SRC_8_IN;
      6'h0a: tbus = TEST_SRC_9_IN;
      6'h0b: tbus = TEST_SRC_10_IN;
      6'h0c: tbus = TEST_SRC_11_IN;
      default: tbus = 36'h000000000;
    endcase
  end

  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN) begin
      RXIN_C_OUT <= 16'h0000;
      RXIN_D_OUT <= 16'h0000;
      DVGA_C_OUT <= 6'h00;
      DVGA_D_OUT <= 6'h00;
      GAIN_FLAG_OUT <= 1'b0;
    end else if (test_sel_q[5:0] != 6'h00) begin
      RXIN_D_OUT <= tbus[35:20];
      DVGA_C_OUT <= {tbus[1:0], tbus[19:18], 1'b0, tb_marks & SYNC_IN};
      RXIN_C_OUT <= tbus[17:2];
      DVGA_D_OUT <= {tb_marks & (above | is_full), 5'h00};
      GAIN_FLAG_OUT <= tb_marks & (above | is_full);
    end
  end

  // ------------------------------------------------------------
  // Gain loop
  // ------------------------------------------------------------
  wire freeze = counts_q[`BIT_FREEZE];
  wire zero_mode = counts_q[3:0] != 4'h0 && zero_run_q >= counts_q[3:0];
  wire sat_mode = counts_q[11:8] != 4'h0 && sat_run_q >= counts_q[11:8];
  always @(posedge CORE_CLK_IN) begin
    if (RESET_IN || counts_q[`BIT_CLEAR]) begin
      AGC_ACC_OUT <= 24'h000000;
      zero_run_q <= 4'h0;
      sat_run_q <= 4'h0;
    end else if (SAMPLE_VALID_IN && !freeze) begin
      zero_run_q <= is_zero ? (zero_run_q == 4'hf ? 4'hf : zero_run_q + 4'h1) : 4'h0;
      sat_run_q <= is_full ? (sat_run_q == 4'hf ? 4'hf : sat_run_q + 4'h1) : 4'h0;
      if (sat_mode && is_full)
        AGC_ACC_OUT <= AGC_ACC_OUT - step_of(steps_q[3:0]);
      else if (zero_mode && is_zero)
        AGC_ACC_OUT <= AGC_ACC_OUT + step_of(steps_q[7:4]);
      else if (above)
        AGC_ACC_OUT <= AGC_ACC_OUT - step_of(steps_q[11:8]);
      else if (below)
        AGC_ACC_OUT <= AGC_ACC_OUT + step_of(steps_q[15:12]);
    end
  end

endmodule

// [test/ddc_chk_properties.sv]
`timescale 1ns/1ps
module ddc_chk (
  // Clock and reset
  input wire CORE_CLK_IN,
  input wire RESET_IN,
  // Bus and events
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire SYNC_IN,
  input wire [17:0] FREQ_ACC_IN,
  // Observed outputs
  input wire [31:0] PRDATA_OUT,
  input wire [15:0] PHASE_B_OUT,
  input wire [15:0] NCO_B_PHASE_OUT,
  input wire [23:0] GAIN_WORD_OUT,
  input wire DITHER_ON_OUT,
  input wire METER_SYNC_OUT,
  input wire MIX_BOOST_OUT,
  input wire [4:0] ROUND_BITS_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (RESET_IN);
  wire wr_take = PSEL_IN & PENABLE_IN & PWRITE_IN;
  property p_nco;
    !$past(RESET_IN) |-> NCO_B_PHASE_OUT == $past(FREQ_ACC_IN[17:2]) + $past(PHASE_B_OUT);
  endproperty
  a_nco: assert property (p_nco) else $error("nco phase sum wrong");
  property p_phase;
    !$past(RESET_IN) && $changed(PHASE_B_OUT) |-> $past(SYNC_IN);
  endproperty
  a_phase: assert property (p_phase) else $error("phase moved without sync");
  property p_gain;
    !$past(RESET_IN) && $changed(GAIN_WORD_OUT) |-> $past(SYNC_IN);
  endproperty
  a_gain: assert property (p_gain) else $error("gain moved without sync");
  property p_meter;
    METER_SYNC_OUT |-> $past(SYNC_IN);
  endproperty
  a_meter: assert property (p_meter) else $error("meter sync without sync");
  property p_rnd;
    ROUND_BITS_OUT >= 5'h03 && ROUND_BITS_OUT <= 5'h12;
  endproperty
  a_rnd: assert property (p_rnd) else $error("round width out of range");
  property p_rndw;
    !$past(RESET_IN) && $changed(ROUND_BITS_OUT) |-> $past(wr_take, 2);
  endproperty
  a_rndw: assert property (p_rndw) else $error("round width moved without write");
  property p_dith;
    !$past(RESET_IN) && $changed(DITHER_ON_OUT) |-> $past(wr_take, 2);
  endproperty
  a_dith: assert property (p_dith) else $error("dither moved without write");
  property p_boost;
    !$past(RESET_IN) && $changed(MIX_BOOST_OUT) |-> $past(wr_take, 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost moved without write");
  property p_rdhi;
    PRDATA_OUT[31:16] == 16'h0000;
  endproperty
  a_rdhi: assert property (p_rdhi) else $error("read data upper half set");
  cover property (SYNC_IN ##1 METER_SYNC_OUT);
  cover property ($changed(PHASE_B_OUT));
  cover property (wr_take ##1 $changed(ROUND_BITS_OUT));
endmodule
bind ddc_channel_control_agc ddc_chk i_chk (.CORE_CLK_IN, .RESET_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
  .SYNC_IN, .FREQ_ACC_IN, .PRDATA_OUT, .PHASE_B_OUT, .NCO_B_PHASE_OUT, .GAIN_WORD_OUT, .DITHER_ON_OUT,
  .METER_SYNC_OUT, .MIX_BOOST_OUT, .ROUND_BITS_OUT);

// [test/ddc_host.sv]
`timescale 1ns/1ps
module ddc_host (
  // Clock
  input wire clk_in,
  // APB master
  output reg psel_out,
  output reg penable_out,
  output reg pwrite_out,
  output reg [11:0] paddr_out,
  output reg [31:0] pwdata_out,
  input wire [31:0] prdata_in,
  input wire pready_in
);
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'h000;
    pwdata_out = 32'h00000000;
  end
  // ----------------------------------------
  // One transfer, held until pready
  // ----------------------------------------
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) @(posedge clk_in);
    q = prdata_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg sync = 1'b0;
  reg sv = 1'b0;
  reg signed [17:0] agc_i = 18'sh0;
  reg [17:0] facc = 18'h3fffc;
  reg [35:0] src [0:11];
  wire psel, pen, pwr, pready, pslverr, dith, msync, clk_en, boost, coef, qz, scnt, spos, flag;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [15:0] phase_b, nco, rxc, rxd;
  wire [23:0] gain;
  wire signed [23:0] acc;
  wire [1:0] dmask;
  wire [4:0] rbits;
  wire [5:0] dvc, dvd;
  int num_errors = 0;
  int samples_checked = 0;
  reg [15:0] mk [0:6] = '{16'hffff, 16'hff07, 16'h003f, 16'hffff, 16'hffff, 16'h1f1f, 16'hffff};
  reg [15:0] cw [0:2] = '{16'hffff, 16'ha905, 16'h0000};
  always #2 clk = ~clk;
  ddc_host i_host (.clk_in(clk), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr), .paddr_out(paddr),
    .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready));
  ddc_channel_control_agc #(.CHANNEL(0)) i_dut (.CORE_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SYNC_IN(sync), .SAMPLE_VALID_IN(sv), .AGC_I_IN(agc_i),
    .FREQ_ACC_IN(facc), .TEST_SRC_0_IN(src[0]), .TEST_SRC_1_IN(src[1]), .TEST_SRC_2_IN(src[2]),
    .TEST_SRC_3_IN(src[3]), .TEST_SRC_4_IN(src[4]), .TEST_SRC_5_IN(src[5]), .TEST_SRC_6_IN(src[6]),
    .TEST_SRC_7_IN(src[7]), .TEST_SRC_8_IN(src[8]), .TEST_SRC_9_IN(src[9]), .TEST_SRC_10_IN(src[10]),
    .TEST_SRC_11_IN(src[11]), .PHASE_B_OUT(phase_b), .NCO_B_PHASE_OUT(nco), .GAIN_WORD_OUT(gain),
    .DITHER_ON_OUT(dith), .DITHER_MASK_OUT(dmask), .METER_SYNC_OUT(msync), .CHAN_CLK_EN_OUT(clk_en),
    .MIX_BOOST_OUT(boost), .COEF_READ_OUT(coef), .Q_ZERO_OUT(qz), .STREAM_CNT_OUT(scnt),
    .SLOT_POS_OUT(spos), .ROUND_BITS_OUT(rbits), .AGC_ACC_OUT(acc), .RXIN_C_OUT(rxc), .RXIN_D_OUT(rxd),
    .DVGA_C_OUT(dvc), .DVGA_D_OUT(dvd), .GAIN_FLAG_OUT(flag));
  // ----------------------------------------
  // Bus, event and compare tasks
  // ----------------------------------------
  function [11:0] ad(input [7:0] i);
    ad = {2'b01, i, 2'b00};
  endfunction
  task chk(input string n, input [35:0] e, input [35:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input [7:0] i, input [31:0] d);
    reg [31:0] q;
    i_host.xfer(1'b1, ad(i), d, q);
  endtask
  task rdc(input [7:0] i, input [15:0] e);
    reg [31:0] q;
    i_host.xfer(1'b0, ad(i), 32'h0, q);
    chk("reg", {20'h0, e}, {4'h0, q});
  endtask
  task pls(input m);
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    #1 chk("meter", 36'(m), 36'(msync));
  endtask
  task smp(input [17:0] v, input [23:0] e);
    @(posedge clk);
    agc_i <= v;
    sv <= 1'b1;
    @(posedge clk) sv <= 1'b0;
    repeat (3) @(posedge clk);
    chk("acc", 36'(e), 36'(acc));
  endtask
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    for (int k = 0; k < 12; k++) src[k] = 36'h123456789 + k * 36'h0f0f0f0f1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk("rbits", 36'd18, 36'(rbits));
    chk("gain", 36'h001000, 36'(gain));
    for (int k = 0; k < 7; k++) rdc(8'h0d + k, 16'h0000);
    rdc(8'h05, 16'h0000);
    for (int k = 0; k < 7; k++) begin
      wr(8'h0d + k, 32'hffffffff);
      rdc(8'h0d + k, mk[k]);
    end
    for (int k = 0; k < 3; k++) begin
      wr(8'h0e, {16'h0, cw[k]});
      repeat (2) @(posedge clk);
      chk("ctl", 36'({cw[k][15:13], cw[k][11], cw[k][9:8], cw[k][2], cw[k][0], cw[k][1]}),
        36'({dith, dmask, clk_en, boost, coef, qz, scnt, spos}));
    end
    wr(8'h0d, 32'h1234);
    wr(8'h13, 32'h0200);
    chk("phase", 36'h0, 36'(phase_b));
    pls(1'b1);
    wr(8'h0e, 32'h1000);
    pls(1'b0);
    wr(8'h0e, 32'h0);
    chk("phase", 36'h1234, 36'(phase_b));
    chk("gain", 36'h021000, 36'(gain));
    chk("nco", 36'h1233, 36'(nco));
    for (int c = 0; c <= 12; c++) begin
      wr(8'h0f, c);
      repeat (3) @(posedge clk);
      chk("tbus", (c == 0) ? 36'h0 : (c == 5 || c == 6) ? {16'h0000, src[c-1][19:0]} : src[c-1],
        {rxd, dvc[3:2], rxc, dvc[5:4]});
    end
    wr(8'h11, 32'h0540);
    repeat (2) @(posedge clk);
    chk("rbits", 36'd13, 36'(rbits));
    wr(8'h11, 32'h0040);
    wr(8'h10, 32'h3433);
    wr(8'h12, 32'h0);
    smp(18'h00001, 24'h100000);
    smp(18'h1fff0, 24'h080000);
    wr(8'h12, 32'h1000);
    smp(18'h00001, 24'h080000);
    wr(8'h12, 32'h0010);
    repeat (2) @(posedge clk);
    chk("acc", 36'h0, 36'(acc));
    finish_test;
  end
  initial begin
    #40000;
    num_errors++;
    finish_test;
  end
endmodule
